// >>> css_defines.svh
// Constants of the clocked serial shift port
// Assumes a 4-bit register file bus and a 16-bit peripheral data buffer
// Summary of operation
// - Enable bit hands three port pins to serial
// - Run bit starts transfer at next falling edge
// - Setting run bit clears the done request
// - Output MSB first on falling edges only
// - Rising edge shifts, serial input into LSB
// - After eight clocks clear run, set done
// - Port line one write changes output latch
// - Float select zero gives full duplex
// - Float select one floats output, receive only
// - Run bit zero means plain storage register
// - Put to 01H loads low data byte
// - Get from 01H returns byte, upper kept
// - Two-bit select picks pin or divided clock
`ifndef CSS_DEFINES_SVH
`define CSS_DEFINES_SVH
// ----------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------
`define CSS_PERI_SHIFT   8'h01
`define CSS_RF_PINS      8'h0a
`define CSS_RF_MODE      8'h1a
// ----------------------------------------------------------------
// Mode and pins register field positions
// ----------------------------------------------------------------
`define CSS_BIT_RUN      3
`define CSS_BIT_FLOAT    2
`define CSS_BIT_CKHI     1
`define CSS_BIT_CKLO     0
`define CSS_BIT_EN       0
// ----------------------------------------------------------------
// Clock select codes and half periods in core cycles minus one
// ----------------------------------------------------------------
`define CSS_CK_EXT       2'h0
`define CSS_CK_D16       2'h1
`define CSS_CK_D128      2'h2
`define CSS_HALF_D16     10'h007
`define CSS_HALF_D128    10'h03f
`define CSS_HALF_D1024   10'h1ff
`define CSS_LAST_BIT     3'h7
`define CSS_RST_NIB      4'h0
`endif

// >>> css_pkg.sv
// Types of the clocked serial shift port
// Assumes css_defines.svh supplies all numbers
package css_pkg;
    // Transfer phase, doubles as the run bit
    typedef enum logic {
        CSS_IDLE = 1'b0,
        CSS_RUN  = 1'b1
    } css_phase_e;

    // Core domain state
    typedef struct packed {
        logic       en;
        logic       hiz;
        logic [1:0] cks;
        css_phase_e ph;
        logic       done;
        logic [7:0] sr;
        logic       so;
        logic [2:0] cnt;
        logic [9:0] div;
        logic       sck;
        logic [2:0] pin_s1;
        logic [2:0] pin_s2;
        logic       tog_s1;
        logic       tog_s2;
        logic       tog_s3;
        logic [3:0] rdata;
        logic [15:0] dbf;
    } css_core_s;

    // Link domain state, rising edge side
    typedef struct packed {
        logic [7:0] rx;
        logic [2:0] cnt;
        logic       tog;
    } css_link_s;
endpackage

// >>> css_port.sv
// Clocked serial shift port: registers, clock divider, shifter, pins
// Assumes the external clock is quiet or steady while run is low and
// that settings and shift word stay put during an external frame
`timescale 1ns/100ps
`include "css_defines.svh"
module css_port
    import css_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        CLK_EN,
    // Register file access
    input  wire logic [7:0]  RF_ADDR,
    input  wire logic        RF_WR,
    input  wire logic        RF_RD,
    input  wire logic [3:0]  RF_WDATA,
    output logic      [3:0]  RF_RDATA,
    // Peripheral put and get through the data buffer
    input  wire logic [7:0]  PERI_ADDR,
    input  wire logic        PERI_PUT,
    input  wire logic        PERI_GET,
    input  wire logic [15:0] DBF_IN,
    output logic      [15:0] DBF_OUT,
    // Port logic sharing the pins
    input  wire logic        PORT_LINE1_WR,
    input  wire logic        PORT_LINE1_DATA,
    input  wire logic [2:0]  PORT_DIR,
    input  wire logic        PORT_LINE0_DATA,
    input  wire logic        PORT_LINE2_DATA,
    output logic      [2:0]  PORT_PIN_LEVEL,
    // Completion request and its clear
    input  wire logic        DONE_REQ_CLR,
    output logic             DONE_REQ,
    // Pins
    input  wire logic        SCK_IN,
    output logic             SCK_OUT,
    output logic             SCK_OE_N,
    input  wire logic        SO_IN,
    output logic             SO_OUT,
    output logic             SO_OE_N,
    input  wire logic        SI_IN,
    output logic             SI_OUT,
    output logic             SI_OE_N
);
    css_core_s q_reg;
    css_core_s q_next;
    css_link_s l_reg;
    css_link_s l_next;
    logic      so_ext_reg;

    logic       is_ext;
    logic       wr_pins;
    logic       wr_mode;
    logic       put_sr;
    logic       tick;
    logic       fall;
    logic       rise;
    logic       ext_fin;
    logic       fin;
    logic [9:0] half;

    // ----------------------------------------------------------------
    // Decode and clock generation
    // ----------------------------------------------------------------
    // Half period of the divided clock, in core cycles minus one
    always_comb begin
        case (q_reg.cks)
            `CSS_CK_D16:  half = `CSS_HALF_D16;
            `CSS_CK_D128: half = `CSS_HALF_D128;
            default:      half = `CSS_HALF_D1024;
        endcase
    end

    assign is_ext  = (q_reg.cks == `CSS_CK_EXT);
    assign wr_pins = RF_WR && (RF_ADDR == `CSS_RF_PINS);
    assign wr_mode = RF_WR && (RF_ADDR == `CSS_RF_MODE);
    assign put_sr  = PERI_PUT && (PERI_ADDR == `CSS_PERI_SHIFT);
    // Divider edges only matter while a transfer runs
    assign tick    = (q_reg.ph == CSS_RUN) && !is_ext && (q_reg.div == half);
    assign fall    = tick && q_reg.sck;
    assign rise    = tick && !q_reg.sck;
    // Link side finished a byte: third sync stage differs from second
    assign ext_fin = q_reg.tog_s2 != q_reg.tog_s3;
    assign fin     = (rise && (q_reg.cnt == `CSS_LAST_BIT)) ||
                     (ext_fin && (q_reg.ph == CSS_RUN) && is_ext);

    // ----------------------------------------------------------------
    // Core next state
    // ----------------------------------------------------------------
    // Register writes, shifting, completion and pin sampling
    always_comb begin
        q_next        = q_reg;
        q_next.pin_s1 = {SI_IN, SO_IN, SCK_IN};
        q_next.pin_s2 = q_reg.pin_s1;
        q_next.tog_s1 = l_reg.tog;
        q_next.tog_s2 = q_reg.tog_s1;
        q_next.tog_s3 = q_reg.tog_s2;
        q_next.rdata  = `CSS_RST_NIB;
        if (RF_RD && (RF_ADDR == `CSS_RF_PINS)) begin
            q_next.rdata[`CSS_BIT_EN] = q_reg.en;
        end
        if (RF_RD && (RF_ADDR == `CSS_RF_MODE)) begin
            q_next.rdata = {q_reg.ph == CSS_RUN, q_reg.hiz, q_reg.cks};
        end
        if (PERI_GET && (PERI_ADDR == `CSS_PERI_SHIFT)) begin
            q_next.dbf = {DBF_IN[15:8], q_reg.sr};
        end
        if (wr_pins) begin
            q_next.en = RF_WDATA[`CSS_BIT_EN];
        end
        // clock select and float select always writable
        if (wr_mode) begin
            q_next.hiz = RF_WDATA[`CSS_BIT_FLOAT];
            q_next.cks = {RF_WDATA[`CSS_BIT_CKHI], RF_WDATA[`CSS_BIT_CKLO]};
        end
        // start with clock high so first edge falls
        if (wr_mode && RF_WDATA[`CSS_BIT_RUN] && q_reg.en && q_reg.ph == CSS_IDLE) begin
            q_next.ph   = CSS_RUN;
            q_next.cnt  = '0;
            q_next.div  = '0;
            q_next.sck  = 1'b1;
            q_next.done = 1'b0;
        end
        // put loads the low byte only
        if (put_sr) begin
            q_next.sr = DBF_IN[7:0];
        end
        // port write lands in the shared latch
        if (PORT_LINE1_WR) begin
            q_next.so = PORT_LINE1_DATA;
        end
        if (q_reg.ph == CSS_RUN && !is_ext) begin
            q_next.div = tick ? '0 : q_reg.div + 10'h001;
            q_next.sck = q_reg.sck ^ tick;
        end
        // MSB out on the falling edge
        if (fall) begin
            q_next.so = q_reg.sr[7];
        end
        if (rise) begin
            q_next.sr  = {q_reg.sr[6:0], q_reg.pin_s2[2]};
            q_next.cnt = q_reg.cnt + 3'h1;
        end
        // External frame result is stable once the toggle arrives
        if (ext_fin && is_ext && q_reg.ph == CSS_RUN) begin
            q_next.sr = l_reg.rx;
            q_next.so = q_reg.sr[0];
        end
        // end of byte; only completion stops a run
        if (fin) begin
            q_next.ph   = CSS_IDLE;
            q_next.sck  = 1'b1;
            q_next.done = 1'b1;
        end else if (DONE_REQ_CLR) begin
            q_next.done = 1'b0;
        end
    end

    // Core register, frozen while the enable is low
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            q_reg     <= '0;
            q_reg.sck <= 1'b1;
        end else if (CLK_EN) begin
            q_reg <= q_next;
        end
    end

    // ----------------------------------------------------------------
    // Link domain on the external clock
    // ----------------------------------------------------------------
    // Run and shift word are static during a frame, read directly
    always_comb begin
        l_next = l_reg;
        if (q_reg.ph == CSS_RUN && is_ext) begin
            l_next.rx  = {l_reg.rx[6:0], SI_IN};
            l_next.cnt = l_reg.cnt + 3'h1;
            if (l_reg.cnt == `CSS_LAST_BIT) begin
                l_next.tog = !l_reg.tog;
            end
        end
    end

    // Rising edge sampling of the input
    always_ff @(posedge SCK_IN or posedge RST) begin
        if (RST) begin
            l_reg <= '0;
        end else if (CLK_EN) begin
            l_reg <= l_next;
        end
    end

    // Falling edge drives the next bit, MSB first
    always_ff @(negedge SCK_IN or posedge RST) begin
        if (RST) begin
            so_ext_reg <= 1'b0;
        end else if (CLK_EN && q_reg.ph == CSS_RUN && is_ext) begin
            so_ext_reg <= q_reg.sr[`CSS_LAST_BIT - l_reg.cnt];
        end
    end

    // ----------------------------------------------------------------
    // Pins and outputs
    // ----------------------------------------------------------------
    // serial use or plain port; output float choice
    always_comb begin
        SCK_OUT  = q_reg.en ? q_reg.sck : PORT_LINE0_DATA;
        SCK_OE_N = q_reg.en ? is_ext : !PORT_DIR[0];
        SO_OUT   = (q_reg.en && is_ext && q_reg.ph == CSS_RUN) ? so_ext_reg : q_reg.so;
        SO_OE_N  = q_reg.en ? q_reg.hiz : !PORT_DIR[1];
        SI_OUT   = PORT_LINE2_DATA;
        SI_OE_N  = q_reg.en || !PORT_DIR[2];
    end

    assign PORT_PIN_LEVEL = q_reg.pin_s2;
    assign RF_RDATA       = q_reg.rdata;
    assign DBF_OUT        = q_reg.dbf;
    assign DONE_REQ       = q_reg.done;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    a_start_clears: assert property (
        CLK_EN && wr_mode && RF_WDATA[3] && q_reg.en && q_reg.ph == CSS_IDLE
        |=> !DONE_REQ && q_reg.ph == CSS_RUN && q_reg.sck)
        else $error("start did not clear request");
    a_zero_ignored: assert property (
        CLK_EN && wr_mode && !RF_WDATA[3] && q_reg.ph == CSS_RUN && !fin
        |=> q_reg.ph == CSS_RUN)
        else $error("zero write stopped transfer");
    a_done_ends: assert property (
        CLK_EN && fin |=> DONE_REQ && q_reg.ph == CSS_IDLE)
        else $error("completion missed");
    a_eight_rises: assert property (
        CLK_EN && rise && q_reg.cnt != 3'h7 |=> q_reg.ph == CSS_RUN)
        else $error("ended before eight bits");
    a_msb_first: assert property (
        CLK_EN && fall |=> SO_OUT == $past(q_reg.sr[7]))
        else $error("output bit not MSB");
    a_shift_in: assert property (
        CLK_EN && rise |=> q_reg.sr[0] == $past(q_reg.pin_s2[2]))
        else $error("input bit not captured");
    a_put_load: assert property (
        CLK_EN && put_sr && !rise && !ext_fin |=> q_reg.sr == $past(DBF_IN[7:0]))
        else $error("put did not load");
    a_get_word: assert property (
        CLK_EN && PERI_GET && PERI_ADDR == `CSS_PERI_SHIFT
        |=> DBF_OUT == {$past(DBF_IN[15:8]), $past(q_reg.sr)})
        else $error("get word wrong");
    a_idle_still: assert property (
        CLK_EN && q_reg.ph == CSS_IDLE && !put_sr |=> $stable(q_reg.sr))
        else $error("shifted while stopped");
    a_float_out: assert property (
        q_reg.en && q_reg.hiz |-> SO_OE_N)
        else $error("output not floated");
    a_int_clock: assert property (
        q_reg.en && !is_ext |-> !SCK_OE_N && SCK_OUT == q_reg.sck)
        else $error("internal clock not driven");

    c_start: cover property (CLK_EN && wr_mode && RF_WDATA[3] && q_reg.en);
    c_int_done: cover property (CLK_EN && fin && !is_ext);
    c_ext_done: cover property (CLK_EN && fin && is_ext);
endmodule

// >>> css_peer.sv
// Far-side model of the clocked serial shift port: slave or clock master
// Assumes the bench resolves pin levels and toggles load before each frame
`timescale 1ns/100ps
module css_peer (
    // Control from the bench
    input  wire logic       ext_go,
    input  wire logic       load,
    input  wire logic [7:0] tx_byte,
    // Resolved pin levels and drives
    input  wire logic       pin_sck,
    input  wire logic       pin_so,
    output logic            sck_drv,
    output logic            si_drv,
    output logic [7:0]      rx_byte
);
    logic [7:0] tx;
    int         k = 8;

    // Idle clock stands high, so the first edge of a frame falls
    initial begin
        sck_drv = 1'b1;
        si_drv  = 1'b0;
        rx_byte = 8'h00;
    end

    always @(ext_go) begin
        #100;
        repeat (8) begin
            sck_drv = 1'b0;
            #24;
            sck_drv = 1'b1;
            #24;
        end
    end

    // Arm a new frame
    always @(load) begin
        tx = tx_byte;
        k  = 0;
    end

    always @(negedge pin_sck) if (k < 8) si_drv = tx[3'(7 - k)];

    // Sample on the rise; past the hold time the line shows junk
    always @(posedge pin_sck) if (k < 8) begin
        rx_byte = {rx_byte[6:0], pin_so};
        k++;
        if (k == 8) si_drv <= #24 ~si_drv;
    end
endmodule

// >>> testbench.sv
// Self-checking bench of css_port against a peer model on its pins
// Assumes 50 MHz core clock and the design's fixed clock dividers
`timescale 1ns/100ps
`include "css_defines.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
    logic        CORE_CLK = 0, RST = 1, CLK_EN = 1, RF_WR = 0, RF_RD = 0;
    logic        PERI_PUT = 0, PERI_GET = 0, PORT_LINE1_WR = 0, PORT_LINE1_DATA = 0;
    logic        PORT_LINE0_DATA = 1, PORT_LINE2_DATA = 0, DONE_REQ_CLR = 0;
    logic [7:0]  RF_ADDR = 0, PERI_ADDR = 0, tx_byte = 0, rx_byte;
    logic [3:0]  RF_WDATA = 0, RF_RDATA, er;
    logic [15:0] DBF_IN = 0, DBF_OUT, eg;
    logic [2:0]  PORT_DIR = 0, PORT_PIN_LEVEL;
    logic        DONE_REQ, SCK_OUT, SCK_OE_N, SO_OUT, SO_OE_N, SI_OUT, SI_OE_N;
    logic        ext_go = 0, load = 0, sck_drv, si_drv, rd_d = 0, get_d = 0;
    logic [3:0]  q_rd[$];
    logic [15:0] q_get[$];
    int          n_errors = 0, comparisons = 0;
    // Pin levels from all drivers; a floated SO output reads back inverted, as junk
    wire         SCK_IN = SCK_OE_N ? sck_drv : SCK_OUT;
    wire         SO_IN  = SO_OE_N ? ~SO_OUT : SO_OUT;
    wire         SI_IN  = SI_OE_N ? si_drv : SI_OUT;

    css_port css_port_i (.CORE_CLK, .RST, .CLK_EN, .RF_ADDR, .RF_WR, .RF_RD, .RF_WDATA,
        .RF_RDATA, .PERI_ADDR, .PERI_PUT, .PERI_GET, .DBF_IN, .DBF_OUT, .PORT_LINE1_WR,
        .PORT_LINE1_DATA, .PORT_DIR, .PORT_LINE0_DATA, .PORT_LINE2_DATA, .PORT_PIN_LEVEL,
        .DONE_REQ_CLR, .DONE_REQ, .SCK_IN, .SCK_OUT, .SCK_OE_N, .SO_IN, .SO_OUT,
        .SO_OE_N, .SI_IN, .SI_OUT, .SI_OE_N);
    css_peer css_peer_i (.ext_go, .load, .tx_byte, .pin_sck(SCK_IN), .pin_so(SO_IN),
        .sck_drv, .si_drv, .rx_byte);

    // Core clock
    always #10 CORE_CLK = ~CORE_CLK;

    // Result watcher: read data shows the cycle after the request is taken
    always @(posedge CORE_CLK) begin
        if (rd_d) begin
            er = q_rd.pop_front();
            `CHK("rf_rdata", er, RF_RDATA)
        end
        if (get_d) begin
            eg = q_get.pop_front();
            `CHK("dbf_out", eg, DBF_OUT)
        end
        rd_d  <= RF_RD;
        get_d <= PERI_GET && PERI_ADDR == `CSS_PERI_SHIFT;
    end

    // Register file write, or read noting d as the expected nibble
    task automatic rf(input logic [7:0] a, input logic wr, input logic [3:0] d);
        @(posedge CORE_CLK);
        RF_ADDR  <= a;
        RF_WDATA <= d;
        RF_WR    <= wr;
        RF_RD    <= !wr;
        if (!wr) q_rd.push_back(d);
        @(posedge CORE_CLK);
        RF_WR <= 0;
        RF_RD <= 0;
    endtask

    // Peripheral put, or get noting d; low byte on the bus is scrambled for a get
    task automatic pg(input logic put, input logic [15:0] d, input logic [7:0] a);
        @(posedge CORE_CLK);
        PERI_ADDR <= a;
        DBF_IN    <= put ? d : d ^ 16'h00ff;
        PERI_PUT  <= put;
        PERI_GET  <= !put;
        if (!put) q_get.push_back(d);
        @(posedge CORE_CLK);
        PERI_PUT <= 0;
        PERI_GET <= 0;
    endtask

    // Port write to the shared output latch
    task automatic ln1(input logic b);
        @(posedge CORE_CLK);
        PORT_LINE1_WR   <= 1;
        PORT_LINE1_DATA <= b;
        @(posedge CORE_CLK);
        PORT_LINE1_WR <= 0;
        @(negedge CORE_CLK);
        `CHK("so_out", b, SO_OUT)
    endtask

    // One frame; mode holds float select and clock select
    task automatic xfer(input logic [3:0] mode);
        logic [7:0] t, r;
        int         i, div;
        t   = 8'($urandom);
        r   = 8'($urandom);
        div = 16 << (3 * (mode[1:0] - 1));
        pg(1, {r, t}, `CSS_PERI_SHIFT);
        @(posedge CORE_CLK);
        tx_byte <= r;
        load    <= ~load;
        rf(`CSS_RF_MODE, 1, 4'h8 | mode);
        @(negedge CORE_CLK);
        `CHK("done_req", 1'b0, DONE_REQ)
        `CHK("sck_oe_n", mode[1:0] == `CSS_CK_EXT, SCK_OE_N)
        `CHK("so_oe_n", mode[2], SO_OE_N)
        rf(`CSS_RF_MODE, 0, 4'h8 | mode);
        rf(`CSS_RF_MODE, 1, mode);
        if (mode[1:0] == `CSS_CK_EXT) ext_go <= ~ext_go;
        for (i = 0; i < 20000 && DONE_REQ !== 1'b1; i++) @(posedge CORE_CLK);
        `CHK("done_req", 1'b1, DONE_REQ)
        if (mode[1:0] != `CSS_CK_EXT) `CHK("frame_len", 1'b1, i inside {[8*div-16:8*div]})
        rf(`CSS_RF_MODE, 0, mode);
        pg(0, {t, r}, `CSS_PERI_SHIFT);
        if (!mode[2]) `CHK("peer_rx", t, rx_byte)
    endtask

    // Verdict
    task automatic close_out;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Watchdog well beyond the slowest frame
    initial begin
        #1_000_000;
        n_errors++;
        close_out();
    end

    // Main sequence
    initial begin
        logic [15:0] w;
        void'($urandom(3342));
        w = 16'($urandom);
        repeat (6) @(posedge CORE_CLK);
        RST <= 0;
        rf(`CSS_RF_PINS, 0, 4'h0);
        rf(`CSS_RF_MODE, 0, 4'h0);
        rf(8'h33, 0, 4'h0);
        // run refused while pins are ports
        rf(`CSS_RF_MODE, 1, 4'h8);
        rf(`CSS_RF_MODE, 0, 4'h0);
        for (int i = 0; i < 8; i++) begin
            @(posedge CORE_CLK);
            PORT_DIR <= 3'(i);
            @(negedge CORE_CLK);
            `CHK("oe_n", ~3'(i), {SI_OE_N, SO_OE_N, SCK_OE_N})
        end
        ln1(w[15]);
        pg(1, w, `CSS_PERI_SHIFT);
        pg(1, ~w, 8'h02);
        @(negedge CORE_CLK);
        `CHK("pin_level", {1'b0, w[15], 1'b1}, PORT_PIN_LEVEL)
        // Frozen clock enable must swallow a register write
        @(posedge CORE_CLK);
        CLK_EN <= 0;
        rf(`CSS_RF_PINS, 1, 4'h1);
        CLK_EN <= 1;
        rf(`CSS_RF_PINS, 0, 4'h0);
        pg(0, {~w[15:8], w[7:0]}, `CSS_PERI_SHIFT);
        rf(`CSS_RF_PINS, 1, 4'h1);
        rf(`CSS_RF_PINS, 0, 4'h1);
        @(negedge CORE_CLK);
        `CHK("si_so_oe_n", 2'b10, {SI_OE_N, SO_OE_N})
        ln1(~w[15]);
        for (int m = 1; m < 5; m++) xfer(4'(m));
        @(posedge CORE_CLK);
        DONE_REQ_CLR <= 1;
        @(posedge CORE_CLK);
        DONE_REQ_CLR <= 0;
        @(negedge CORE_CLK);
        `CHK("done_req", 1'b0, DONE_REQ)
        close_out();
    end
endmodule
